/* File: src/eeprom_cmd_cfg.svh */
// Constants for the serial data memory command engine
`ifndef EEPROM_CMD_CFG_SVH
`define EEPROM_CMD_CFG_SVH
// Header length: start bit, two opcode bits, nine address bits
`define EE_HDR_BITS 4'd12
`define EE_DATA_BITS 4'd8
// Opcodes
`define EE_OP_EXT 2'b00
`define EE_OP_WRITE 2'b01
`define EE_OP_READ 2'b10
`define EE_OP_ERASE 2'b11
// Extended selectors, top two bits of the address field
`define EE_EXT_DIS 2'b00
`define EE_EXT_WRITE_ALL_CMD 2'b01
`define EE_EXT_ERASE_ALL_CMD 2'b10
`define EE_EXT_EN 2'b11
// Control register bit positions
`define EE_CR_SEL_BIT 4
`define EE_CR_SCK_BIT 5
`define EE_CR_SIN_BIT 6
`define EE_CR_SOUT_BIT 7
// Erased byte value
`define EE_ERASED 8'hff
// Self-timed program time, per byte, in ns
`define EE_PROG_NS 2000000
// Cycles at 8 ns, rounded down (longest time)
`define EE_PROG_CYC (`EE_PROG_NS / 8)
`endif

/* File: src/eeprom_cmd_pkg.sv */
// Types for the serial data memory command engine
`default_nettype none
package eeprom_cmd_pkg;
  // Link pins as seen by the engine
  typedef struct packed {
    logic sel;
    logic sck;
    logic sin;
  } link_in_t;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_ARMED = 3'b100,
    ST_BUSY = 3'b101,
    ST_DONE = 3'b110
  } state_t;
  // Pending program operation
  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_WRITE = 2'b01,
    OP_ERASE_ALL_CMD = 2'b10,
    OP_WRITE_ALL_CMD = 2'b11
  } prog_t;
endpackage : eeprom_cmd_pkg
`default_nettype wire

/* File: src/eeprom_array.sv */
// 256 by 8 storage array with single or whole-array programming
`default_nettype none
module eeprom_array (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Access
  input wire logic [7:0] addr,
  output logic [7:0] rdata,
  input wire logic wr,
  input wire logic wr_all,
  input wire logic [7:0] wdata
);
  logic [7:0] mem_r [0:255];

  // Cells keep contents over reset, as nonvolatile storage would
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int i = 0; i < 256; i++) begin
        if (wr_all || (wr && addr == 8'(i))) begin
          mem_r[i] <= wdata;
        end
      end
    end
  end

  assign rdata = mem_r[addr];
endmodule : eeprom_array
`default_nettype wire

/* File: src/eeprom_cmd_engine.sv */
// Serial data memory command engine behind the three-wire line register
//
// Overview of operation
// R1 - Read shifts a zero dummy bit then 8 data bits, changing on shift_clock rise.
// R2 - Reads work whether programming is enabled or not.
// R3 - After each read byte the address steps by one.
// R4 - Sequential reads wrap the address; they end when select falls.
// R5 - Reset puts the engine in programming-disabled state.
// R6 - Write, erase, write-all, erase-all are ignored unless programming is enabled.
// R7 - Enable persists until the disable instruction or reset.
// R8 - Erase starts on select falling and is internally timed.
// R9 - Write starts on select falling and is internally timed.
// R10 - A byte write erases its location first, automatically.
// R11 - Erase-all sets all 256 bytes to all ones.
// R12 - Write-all writes the given byte to all 256 locations.
// R13 - Output low while busy with select high, high when done.
// R14 - Header: start 1, opcode 10 read, 11 erase, 01 write, then nine address bits.
// R15 - Opcode 00 field 11 enables, 00 disables, 10 erases all.
// R16 - Opcode 00 field 01 is write-all and carries eight data bits.
// R17 - Header is 12 bits; serial_in sampled on shift_clock rising edges.
// R18 - Output is high whenever select is low.
// R19 - Controller drops select after the last bit for the instruction to act.
// R20 - Control bit 4 select, 5 shift_clock, 6 serial_in, 7 output; 0..3 read zero.
`include "eeprom_cmd_cfg.svh"
`default_nettype none
module eeprom_cmd_engine #(
  parameter int unsigned PROG_CYC = `EE_PROG_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port for eeprom_line_control_reg
  input wire logic reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Engine status
  output logic busy,
  output logic prog_enabled
);
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;
  eeprom_cmd_pkg::link_in_t line_r;
  logic sck_d_r;
  logic sout_r;
  eeprom_cmd_pkg::state_t state_r;
  eeprom_cmd_pkg::prog_t prog_r;
  logic [3:0] cnt_r;
  logic [11:0] hdr_r;
  logic [7:0] addr_r;
  logic [7:0] data_r;
  logic [7:0] shift_r;
  logic en_r;
  logic [31:0] tmr_r;
  logic phase_r;
  logic sck_rise;
  logic sel_fall;
  logic mem_wr;
  logic mem_wr_all;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] hdr_addr_nxt;
  logic hdr_last;
  logic prog_last;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // Line bits written by the core; same clock, so used directly
  // A write while clk_en is low is lost; the core is frozen with the engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= '0;
    end else if (clk_en && reg_wr && reg_addr == 1'b0) begin
      line_r.sel <= reg_wdata[`EE_CR_SEL_BIT]; // [R20]
      line_r.sck <= reg_wdata[`EE_CR_SCK_BIT]; // [R20]
      line_r.sin <= reg_wdata[`EE_CR_SIN_BIT]; // [R20]
    end
  end

  // Previous levels for edge finding
  // Both reset low like the idle pins, so reset leaves no false edge
  logic sel_d_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b0;
    end else if (clk_en) begin
      sck_d_r <= line_r.sck;
      sel_d_r <= line_r.sel;
    end
  end
  assign sck_rise = line_r.sck && !sck_d_r && line_r.sel; // [R17]
  assign sel_fall = sel_d_r && !line_r.sel;

  // Header is complete when the twelfth bit lands
  assign hdr_last = (state_r == eeprom_cmd_pkg::ST_HDR) && sck_rise
                    && cnt_r == (`EE_HDR_BITS - 4'd1);
  assign hdr_addr_nxt = {hdr_r[6:0], line_r.sin};

  // Last cycle of one program step; the sequencer and the array strobes share it
  assign prog_last = (state_r == eeprom_cmd_pkg::ST_BUSY) && (tmr_r == PROG_CYC - 1);

  // A complete header is held as start, opcode, then the nine-bit field
  function automatic logic ext_is(input logic [11:0] h, input logic [1:0] s);
    return (h[10:9] == `EE_OP_EXT) && (h[8:7] == s);
  endfunction : ext_is

  // Main sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= eeprom_cmd_pkg::ST_IDLE;
      prog_r <= eeprom_cmd_pkg::OP_ERASE;
      cnt_r <= 4'd0;
      hdr_r <= 12'h000;
      addr_r <= 8'h00;
      data_r <= 8'h00;
      shift_r <= 8'h00;
      tmr_r <= 32'h0000_0000;
      phase_r <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        eeprom_cmd_pkg::ST_IDLE: begin
          // Leading zeros before the start bit are skipped
          if (sck_rise && line_r.sin) begin // [R14]
            hdr_r <= 12'h001;
            cnt_r <= 4'd1;
            state_r <= eeprom_cmd_pkg::ST_HDR;
          end
        end
        eeprom_cmd_pkg::ST_HDR: begin
          if (!line_r.sel) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE;
          end else if (sck_rise) begin
            hdr_r <= {hdr_r[10:0], line_r.sin}; // [R17]
            cnt_r <= cnt_r + 4'd1;
            if (hdr_last) begin
              cnt_r <= 4'd0;
              addr_r <= hdr_addr_nxt;
              unique case (hdr_r[9:8])
                `EE_OP_READ: begin
                  // Dummy zero goes out first, then eight data bits
                  shift_r <= 8'h00; // [R1] [R2]
                  state_r <= eeprom_cmd_pkg::ST_READ;
                end
                `EE_OP_WRITE: begin
                  prog_r <= eeprom_cmd_pkg::OP_WRITE;
                  state_r <= eeprom_cmd_pkg::ST_DATA;
                end
                `EE_OP_ERASE: begin
                  prog_r <= eeprom_cmd_pkg::OP_ERASE; // [R8]
                  state_r <= eeprom_cmd_pkg::ST_ARMED;
                end
                `EE_OP_EXT: begin
                  unique case (hdr_r[7:6])
                    `EE_EXT_WRITE_ALL_CMD: begin
                      prog_r <= eeprom_cmd_pkg::OP_WRITE_ALL_CMD; // [R16]
                      state_r <= eeprom_cmd_pkg::ST_DATA;
                    end
                    `EE_EXT_ERASE_ALL_CMD: begin
                      prog_r <= eeprom_cmd_pkg::OP_ERASE_ALL_CMD; // [R15]
                      state_r <= eeprom_cmd_pkg::ST_ARMED;
                    end
                    // Enable and disable act at select fall, see below
                    default: state_r <= eeprom_cmd_pkg::ST_DONE;
                  endcase
                end
              endcase
            end
          end
        end
        eeprom_cmd_pkg::ST_DATA: begin
          // Eight data bits follow a write or write-all header, MSB first
          if (!line_r.sel) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE; // Short data: dropped
          end else if (sck_rise) begin
            data_r <= {data_r[6:0], line_r.sin};
            cnt_r <= cnt_r + 4'd1;
            if (cnt_r == `EE_DATA_BITS - 4'd1) begin
              state_r <= eeprom_cmd_pkg::ST_ARMED;
            end
          end
        end
        eeprom_cmd_pkg::ST_READ: begin
          if (!line_r.sel) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE; // [R4]
          end else if (sck_rise) begin
            // Rise with count 0 loads the byte after its dummy; rises 1 to 7 shift it;
            // the ninth rise puts out the next byte's dummy and steps the address
            if (cnt_r == `EE_DATA_BITS) begin
              addr_r <= addr_r + 8'h01; // [R3] [R4]
              shift_r <= 8'h00; // [R1]
              cnt_r <= 4'd0;
            end else if (cnt_r == 4'd0) begin
              shift_r <= mem_rdata; // [R1]
              cnt_r <= 4'd1;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'd1;
            end
          end
        end
        eeprom_cmd_pkg::ST_ARMED: begin
          // Program starts only on select falling, with enable held
          if (sel_fall) begin // [R8] [R9] [R19]
            // A refused instruction drops back to idle and reports ready at once
            if (en_r) begin // [R6]
              tmr_r <= 32'h0000_0000;
              phase_r <= 1'b0;
              state_r <= eeprom_cmd_pkg::ST_BUSY;
            end else begin
              state_r <= eeprom_cmd_pkg::ST_IDLE;
            end
          end
        end
        eeprom_cmd_pkg::ST_BUSY: begin
          // Write runs erase then program, each one full program time
          // Select may toggle meanwhile; status is only visible with select high
          if (prog_last) begin
            tmr_r <= 32'h0000_0000;
            if (prog_r == eeprom_cmd_pkg::OP_WRITE && !phase_r) begin
              phase_r <= 1'b1; // [R10]
            end else begin
              state_r <= eeprom_cmd_pkg::ST_DONE;
            end
          end else begin
            tmr_r <= tmr_r + 32'h0000_0001;
          end
        end
        eeprom_cmd_pkg::ST_DONE: begin
          // Wait for select low before a new instruction
          if (!line_r.sel) begin
            state_r <= eeprom_cmd_pkg::ST_IDLE;
          end
        end
        default: state_r <= eeprom_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // Programming enable latch; enable and disable act at select fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0; // [R5]
    end else if (clk_en && sel_fall && state_r == eeprom_cmd_pkg::ST_DONE
                 && cnt_r == 4'd0) begin
      // The header has shifted fully in by now, so its field sits one place higher
      if (ext_is(hdr_r, `EE_EXT_EN)) begin
        en_r <= 1'b1; // [R7] [R15]
      end else if (ext_is(hdr_r, `EE_EXT_DIS)) begin
        en_r <= 1'b0; // [R15]
      end
    end
  end

  // Array strobes fire on the last cycle of each program step
  always_comb begin
    mem_wr = 1'b0;
    mem_wr_all = 1'b0;
    mem_wdata = `EE_ERASED;
    if (prog_last) begin
      unique case (prog_r)
        eeprom_cmd_pkg::OP_ERASE: mem_wr = 1'b1; // [R8]
        eeprom_cmd_pkg::OP_WRITE: begin
          mem_wr = 1'b1; // [R9] [R10]
          mem_wdata = phase_r ? data_r : `EE_ERASED;
        end
        eeprom_cmd_pkg::OP_ERASE_ALL_CMD: mem_wr_all = 1'b1; // [R11]
        eeprom_cmd_pkg::OP_WRITE_ALL_CMD: begin
          mem_wr_all = 1'b1; // [R12]
          mem_wdata = data_r;
        end
      endcase
    end
  end

  // Storage has no reset: contents are unknown until first programmed
  eeprom_array u_array (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .addr(addr_r),
    .rdata(mem_rdata),
    .wr(mem_wr),
    .wr_all(mem_wr_all),
    .wdata(mem_wdata)
  );

  // Serial output: high when deselected, busy low, read bit while reading, high otherwise
  // The bit trails a shift clock write by two cycles, far inside one bit time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_r <= 1'b1;
    end else if (clk_en) begin
      if (!line_r.sel) begin
        sout_r <= 1'b1; // [R18]
      end else if (state_r == eeprom_cmd_pkg::ST_BUSY) begin
        sout_r <= 1'b0; // [R13]
      end else if (state_r == eeprom_cmd_pkg::ST_READ) begin
        sout_r <= shift_r[7]; // [R1]
      end else begin
        sout_r <= 1'b1; // [R13]
      end
    end
  end

  // Read data one cycle after the strobe; low nibble reads zero
  // Idle and unmapped cycles read zero so stale line data never lingers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd && reg_addr == 1'b0) begin
        reg_rdata <= {sout_r, line_r.sin, line_r.sck, line_r.sel, 4'h0}; // [R20]
      end
    end
  end

  // Status outputs from flops
  // prog_enabled trails the latch by a cycle, well inside instruction spacing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      prog_enabled <= 1'b0;
    end else if (clk_en) begin
      busy <= (state_r == eeprom_cmd_pkg::ST_BUSY);
      prog_enabled <= en_r;
    end
  end
endmodule : eeprom_cmd_engine
`default_nettype wire

/* File: sim/eeprom_cmd_props.sv */
// Assertion checker for the command engine register port
`default_nettype none
module eeprom_cmd_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Register port
  input wire logic reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic busy,
  input wire logic prog_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] quiet_r;
  logic [2:0] ctl_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Age of the last line write; the output bit needs two cycles to settle after it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet_r <= 2'h3;
      ctl_r <= 3'h0;
    end else if (clk_en && reg_wr && !reg_addr) begin
      quiet_r <= 2'h0;
      ctl_r <= reg_wdata[6:4];
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");
  a_low_nibble: assert property (reg_rdata[3:0] == 4'h0)
    else $error("unused control bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_readback: assert property (reg_rd && !reg_addr |=> reg_rdata[6:4] == ctl_r)
    else $error("line bits not read back");
  a_busy_needs_en: assert property ($rose(busy) |-> prog_enabled)
    else $error("programming started while disabled");
  a_busy_on_fall: assert property ($rose(busy) |-> !ctl_r[0])
    else $error("programming started with select high");
  a_enable_on_fall: assert property ($changed(prog_enabled) |-> !ctl_r[0])
    else $error("enable state changed without select fall");
  a_desel_high: assert property (reg_rd && !reg_addr && quiet_r == 2'h3
      |=> reg_rdata[4] || reg_rdata[7])
    else $error("output low with select low");
  a_busy_out_low: assert property (reg_rd && !reg_addr && quiet_r == 2'h3 && busy
      && $past(busy) ##1 busy |-> !reg_rdata[7] || !reg_rdata[4])
    else $error("output high while busy");
endmodule : eeprom_cmd_props
bind eeprom_cmd_engine eeprom_cmd_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .prog_enabled(prog_enabled));
`default_nettype wire

/* File: sim/mcu_line_model.sv */
// Model of the controller core driving the three-wire line through its register
`default_nettype none
module mcu_line_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    reg_addr = 1'b0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read strobe; data exists only in the following cycle
  task automatic rd(input logic a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd
  // Each level held 8 cycles, so the shift clock period is near 128 ns
  task automatic line(input logic sel, input logic sck, input logic sin);
    wr(1'b0, {1'b0, sin, sck, sel, 4'h0});
    repeat (7) @(posedge ref_clk);
  endtask : line
  // MSB first, each bit taken on a shift clock rise
  task automatic send(input logic [11:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      line(1'b1, 1'b0, b[i]);
      line(1'b1, 1'b1, b[i]);
    end
  endtask : send
  // Twelve-bit header, optional data, then select low so it takes effect
  task automatic cmd(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
      input logic wd);
    line(1'b1, 1'b0, 1'b0);
    send({1'b1, op, a}, 12);
    if (wd) begin
      send({4'h0, d}, 8);
    end
    line(1'b0, 1'b0, 1'b0);
  endtask : cmd
  // Read header only; select stays high to stream bytes
  task automatic start_read(input logic [8:0] a);
    line(1'b1, 1'b0, 1'b0);
    send({1'b1, 2'b10, a}, 12);
  endtask : start_read
  // One shift clock pulse, then the settled output bit
  task automatic pulse(output logic b);
    logic [7:0] d;
    line(1'b1, 1'b0, 1'b0);
    line(1'b1, 1'b1, 1'b0);
    rd(1'b0, d);
    b = d[7];
  endtask : pulse
  // Dummy bit then eight data bits; the first dummy is out as soon as the header ends
  task automatic get_byte(input logic first, output logic dummy, output logic [7:0] v);
    logic [7:0] d;
    if (first) begin
      line(1'b1, 1'b0, 1'b0);
      rd(1'b0, d);
      dummy = d[7];
    end else begin
      pulse(dummy);
    end
    for (int i = 7; i >= 0; i--) begin
      pulse(v[i]);
    end
  endtask : get_byte
  // Nothing new is sent until the status shows ready; bounded so a stuck engine ends it
  task automatic wait_ready(output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    line(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 8000 && !ok; i++) begin
      rd(1'b0, d);
      ok = (d[7] === 1'b1);
    end
    line(1'b0, 1'b0, 1'b0);
  endtask : wait_ready
endmodule : mcu_line_model
`default_nettype wire

/* File: sim/eeprom_cmd_engine_tb.sv */
// Self-checking bench for the command engine
`include "eeprom_cmd_cfg.svh"
`default_nettype none
module eeprom_cmd_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PROG_CYC = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic busy;
  logic prog_enabled;
  int miscompares = 0;
  int comparisons = 0;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  eeprom_cmd_engine #(.PROG_CYC(PROG_CYC)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .prog_enabled(prog_enabled));
  mcu_line_model mcu (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // Instruction plus status poll until ready
  task automatic prog(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
      input logic wd);
    logic ok;
    mcu.cmd(op, a, d, wd);
    mcu.wait_ready(ok);
    check({7'h0, ok}, 8'h01);
  endtask : prog
  // Streams two bytes from one address
  task automatic read_chk(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic dm;
    logic [7:0] v;
    mcu.start_read(a);
    mcu.get_byte(1'b1, dm, v);
    check({7'h0, dm}, 8'h00);
    check(v, e0);
    mcu.get_byte(1'b0, dm, v);
    check({7'h0, dm}, 8'h00);
    check(v, e1);
    mcu.line(1'b0, 1'b0, 1'b0);
  endtask : read_chk
  task automatic t_reset;
    logic [7:0] d;
    check({6'h0, busy, prog_enabled}, 8'h00);
    mcu.rd(1'b1, d);
    check(d, 8'h00);
    mcu.rd(1'b0, d);
    check(d, 8'h80);
    $display("test reset done");
  endtask : t_reset
  // Enable, erase all, disable, then a refused write
  task automatic t_lock;
    prog(`EE_OP_EXT, {`EE_EXT_EN, 7'h00}, 8'h00, 1'b0);
    check({7'h0, prog_enabled}, 8'h01);
    prog(`EE_OP_EXT, {`EE_EXT_ERASE_ALL_CMD, 7'h55}, 8'h00, 1'b0);
    read_chk(9'h0fe, 8'hff, 8'hff);
    prog(`EE_OP_EXT, {`EE_EXT_DIS, 7'h7f}, 8'h00, 1'b0);
    check({7'h0, prog_enabled}, 8'h00);
    prog(`EE_OP_WRITE, 9'h005, 8'h3c, 1'b1);
    check({7'h0, busy}, 8'h00);
    read_chk(9'h005, 8'hff, 8'hff);
    $display("test lock done");
  endtask : t_lock
  // Writes, busy status, overwrite needs the automatic erase
  task automatic t_write;
    logic [7:0] d;
    logic ok;
    prog(`EE_OP_EXT, {`EE_EXT_EN, 7'h2a}, 8'h00, 1'b0);
    mcu.cmd(`EE_OP_WRITE, 9'h105, 8'h3c, 1'b1);
    mcu.rd(1'b0, d);
    check({d[7], 6'h0, busy}, 8'h81);
    mcu.line(1'b1, 1'b0, 1'b0);
    mcu.rd(1'b0, d);
    check(d, 8'h10);
    // Clock enable low freezes the engine mid-program, busy included
    clk_en <= 1'b0;
    repeat (50) @(posedge ref_clk);
    check({7'h0, busy}, 8'h01);
    clk_en <= 1'b1;
    mcu.wait_ready(ok);
    check({7'h0, ok}, 8'h01);
    prog(`EE_OP_WRITE, 9'h005, 8'hc3, 1'b1);
    prog(`EE_OP_WRITE, 9'h006, 8'ha5, 1'b1);
    read_chk(9'h005, 8'hc3, 8'ha5);
    $display("test write done");
  endtask : t_write
  task automatic t_erase;
    prog(`EE_OP_ERASE, 9'h006, 8'h00, 1'b0);
    read_chk(9'h005, 8'hc3, 8'hff);
    $display("test erase done");
  endtask : t_erase
  // Write all, then a read that wraps from the top address
  task automatic t_write_all_cmd;
    prog(`EE_OP_EXT, {`EE_EXT_WRITE_ALL_CMD, 7'h00}, 8'h5a, 1'b1);
    prog(`EE_OP_WRITE, 9'h000, 8'h01, 1'b1);
    read_chk(9'h0ff, 8'h5a, 8'h01);
    read_chk(9'h080, 8'h5a, 8'h5a);
    $display("test write all done");
  endtask : t_write_all_cmd
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_lock;
    t_write;
    t_erase;
    t_write_all_cmd;
    stop_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    stop_test;
  end
endmodule : eeprom_cmd_engine_tb
`default_nettype wire
